// ---- pss_pkg.sv ----
package pss_pkg;
  // Bus address and pointer layout
  localparam logic [6:0] PSS_SLAVE_ADDR   = 7'h36;
  localparam logic [7:0] PSS_PTR_RESET    = 8'h00;
  localparam logic [7:0] PSS_BYTE_ZERO    = 8'h00;
  localparam logic [7:0] PSS_PTR_STEP     = 8'h01;
  // Valid register windows (inclusive ranges)
  localparam logic [7:0] PSS_CFG_LO       = 8'h00;
  localparam logic [7:0] PSS_CFG_HI       = 8'h08;
  localparam logic [7:0] PSS_OUT_LO       = 8'h0B;
  localparam logic [7:0] PSS_OUT_HI       = 8'h10;
  localparam logic [7:0] PSS_BURN_ADDR    = 8'hFF;
  // High bytes of the position registers that hold the pointer on reads, then the magnitude low, status and AGC addresses
  localparam logic [7:0] PSS_RAW_HI       = 8'h0C;
  localparam logic [7:0] PSS_ANG_HI       = 8'h0E;
  localparam logic [7:0] PSS_MAG_HI       = 8'h1B;
  localparam logic [7:0] PSS_MAG_LO       = 8'h1C;
  localparam logic [7:0] PSS_STAT_ADDR    = 8'h0B;
  localparam logic [7:0] PSS_AGC_ADDR     = 8'h1A;
  // Timing: glitch filter width
  localparam int         PSS_CLK_NS       = 25;
  localparam int         PSS_GLITCH_NS    = 50;
  localparam int         PSS_FILT_CYC     = (PSS_GLITCH_NS + PSS_CLK_NS - 1) / PSS_CLK_NS;
  localparam logic [2:0] PSS_FILT_N       = 3'(PSS_FILT_CYC);
  localparam logic [3:0] PSS_BIT_LAST     = 4'h7;
  localparam logic [3:0] PSS_BIT_ACK      = 4'h8;
  localparam logic [3:0] PSS_BIT_ZERO     = 4'h0;

  typedef enum logic [2:0] {
    PSS_IDLE  = 3'b000,
    PSS_ADDR  = 3'b001,
    PSS_WPTR  = 3'b010,
    PSS_WDAT  = 3'b011,
    PSS_RDAT  = 3'b100,
    PSS_SKIP  = 3'b101
  } pss_state_t;

  // Location holds a real register
  function automatic logic pss_valid(input logic [7:0] a);
    pss_valid = (a <= PSS_CFG_HI) || (a >= PSS_OUT_LO && a <= PSS_OUT_HI) ||
                (a >= PSS_AGC_ADDR && a <= PSS_MAG_LO) || (a == PSS_BURN_ADDR);
  endfunction : pss_valid
endpackage : pss_pkg

// ---- pss_glitch_filt.sv ----
`timescale 1ns/1ps
`default_nettype none
module pss_glitch_filt
  import pss_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic pin_in,
  output var  logic clean
);
  logic       s1_reg;
  logic       s2_reg;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic       clean_next;

  // Level must differ for more than the glitch width before it is taken
  assign cnt_next   = (s2_reg == clean) ? 3'h0 : cnt_reg + 3'h1;
  assign clean_next = (s2_reg != clean) && (cnt_reg >= PSS_FILT_N) ? s2_reg : clean;

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser then persistence counter
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_reg  <= 1'b1;
      s2_reg  <= 1'b1;
      cnt_reg <= 3'h0;
      clean   <= 1'b1;
    end else begin
      s1_reg  <= pin_in;
      s2_reg  <= s1_reg;
      cnt_reg <= cnt_next;
      clean   <= clean_next;
    end
  end

  short_pulse_a: assert property (@(posedge mclk) disable iff (rst)
    $changed(clean) |-> $past(s2_reg, 1) == clean && $past(s2_reg, 2) == clean)
    else $error("filter passed a short pulse");
endmodule : pss_glitch_filt
`default_nettype wire

// ---- pss_i2c_slave.sv ----
// How it works
// - Only a slave: never drives the clock, never makes START or STOP.
// - Answers only to 7-bit address 0x36.
// - No clock stretching; answers are ready while the clock is low.
// - Data sampled on clock rise; data driven only while clock low.
// - Pulses under 50 ns on either line are filtered out.
// - Clock is input only; data is pulled low or released.
// - First written byte loads the pointer; pointer then steps per byte.
// - Unused pointer byte not acknowledged; reads there give zero; pointer wraps.
// - Pointer holds on reads set to position high bytes.
// - Writes to unused locations not acknowledged; pointer still steps.
`timescale 1ns/1ps
`default_nettype none
module pss_i2c_slave
  import pss_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output var  logic       sda_out,
  output var  logic       sda_oe_n,
  input  wire logic [7:0] rd_data,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] wr_data,
  output var  logic       wr_stb,
  output var  logic       busy
);
  logic       scl_f;
  logic       sda_f;
  logic       scl_d_reg;
  logic       sda_d_reg;
  pss_state_t st_reg;
  pss_state_t st_next;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg;
  logic [7:0] ptr_reg;
  logic       rw_reg;
  logic       hold_reg;
  logic       mack_reg;
  logic       armed_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Input filters on both lines
  pss_glitch_filt u_scl (.mclk(mclk), .rst(rst), .pin_in(scl_in), .clean(scl_f));
  pss_glitch_filt u_sda (.mclk(mclk), .rst(rst), .pin_in(sda_in), .clean(sda_f));

  // Bus event decode
  wire scl_rise  = scl_f & ~scl_d_reg;
  wire scl_fall  = ~scl_f & scl_d_reg;
  wire start_cnd = scl_f & scl_d_reg & sda_d_reg & ~sda_f;
  wire stop_cnd  = scl_f & scl_d_reg & ~sda_d_reg & sda_f;
  wire [7:0] sh_in    = {sh_reg[6:0], sda_f};
  wire       addr_hit = (sh_reg[7:1] == PSS_SLAVE_ADDR);
  wire       ptr_ok   = pss_valid(sh_reg);
  wire       cur_ok   = pss_valid(ptr_reg);
  wire [7:0] ptr_inc  = ptr_reg + PSS_PTR_STEP;
  wire       pos_hi   = (ptr_reg == PSS_RAW_HI) || (ptr_reg == PSS_ANG_HI) ||
                        (ptr_reg == PSS_MAG_HI);
  wire [7:0] rd_byte  = cur_ok ? rd_data : PSS_BYTE_ZERO;
  wire       in_ack   = (bit_reg == PSS_BIT_ACK);
  // Clock fall that ends a START hold is not a bit boundary
  wire       bit_fall = scl_fall && armed_reg;
  wire       byte_end = bit_fall && (bit_reg == PSS_BIT_LAST);
  wire       ack_end  = bit_fall && in_ack;

  // Ack decision for the byte just received
  wire ack_now = (st_reg == PSS_ADDR) ? addr_hit :
                 (st_reg == PSS_WPTR) ? ptr_ok : (st_reg == PSS_WDAT) ? cur_ok : 1'b0;

  // Next state at end of each acknowledge slot
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      PSS_ADDR: st_next = !addr_hit ? PSS_SKIP : (rw_reg ? PSS_RDAT : PSS_WPTR);
      PSS_WPTR: st_next = PSS_WDAT;
      PSS_WDAT: st_next = PSS_WDAT;
      PSS_RDAT: st_next = mack_reg ? PSS_SKIP : PSS_RDAT;
      PSS_SKIP: st_next = PSS_SKIP;
      PSS_IDLE: st_next = PSS_IDLE;
      default:  st_next = PSS_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge history
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_f;
      sda_d_reg <= sda_f;
    end
  end

  // Byte framing, pointer and data line control
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg   <= PSS_IDLE;
      bit_reg  <= PSS_BIT_ZERO;
      sh_reg   <= PSS_BYTE_ZERO;
      ptr_reg  <= PSS_PTR_RESET;
      rw_reg   <= 1'b0;
      hold_reg <= 1'b0;
      mack_reg <= 1'b1;
      armed_reg <= 1'b0;
      sda_out  <= 1'b0;
      sda_oe_n <= 1'b1;
      wr_data  <= PSS_BYTE_ZERO;
      wr_stb   <= 1'b0;
      busy     <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      if (start_cnd) begin
        st_reg   <= PSS_ADDR;
        bit_reg  <= PSS_BIT_ZERO;
        sda_oe_n <= 1'b1;
        busy     <= 1'b1;
        armed_reg <= 1'b0;
      end else if (stop_cnd) begin
        st_reg   <= PSS_IDLE;
        sda_oe_n <= 1'b1;
        busy     <= 1'b0;
      end else if (st_reg != PSS_IDLE && st_reg != PSS_SKIP) begin
        if (scl_rise) begin
          armed_reg <= 1'b1;
          if (in_ack) begin
            mack_reg <= sda_f;
          end else if (!(st_reg == PSS_RDAT)) begin
            sh_reg <= sh_in;
          end
        end
        if (byte_end) begin
          bit_reg <= PSS_BIT_ACK;
          // Drive ack low, or release for NACK and for master ack slot
          sda_oe_n <= !(st_reg != PSS_RDAT && ack_now);
          if (st_reg == PSS_WPTR) begin
            ptr_reg  <= sh_reg;
            hold_reg <= 1'b0;
          end else if (st_reg == PSS_WDAT) begin
            wr_data <= sh_reg;
            wr_stb  <= cur_ok;
            ptr_reg <= ptr_inc;
          end else if (st_reg == PSS_RDAT) begin
            ptr_reg <= hold_reg ? ptr_reg : ptr_inc;
          end
          if (st_reg == PSS_ADDR) begin
            rw_reg   <= sh_reg[0];
            hold_reg <= pos_hi;
          end
        end else if (ack_end) begin
          bit_reg <= PSS_BIT_ZERO;
          st_reg  <= st_next;
          if (st_next == PSS_RDAT) begin
            sda_oe_n <= rd_byte[7];
            sh_reg   <= {rd_byte[6:0], 1'b0};
          end else begin
            sda_oe_n <= 1'b1;
          end
        end else if (bit_fall) begin
          bit_reg <= bit_reg + 4'h1;
          if (st_reg == PSS_RDAT) begin
            sda_oe_n <= sh_reg[7];
            sh_reg   <= {sh_reg[6:0], 1'b0};
          end
        end
      end
    end
  end

  // Pointer presented to the register space
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_addr <= PSS_PTR_RESET;
    end else begin
      reg_addr <= ptr_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data line and framing checks
  sda_low_only_a: assert property (@(posedge mclk) disable iff (rst)
    sda_out == 1'b0) else $error("data line driven high");
  drive_clk_low_a: assert property (@(posedge mclk) disable iff (rst)
    (!sda_oe_n && $changed(sda_oe_n)) |-> !scl_f) else $error("data changed while clock high");
  stop_release_a: assert property (@(posedge mclk) disable iff (rst)
    stop_cnd |=> sda_oe_n && !busy) else $error("bus not released on stop");
  start_frame_a: assert property (@(posedge mclk) disable iff (rst)
    start_cnd |=> st_reg == PSS_ADDR && bit_reg == PSS_BIT_ZERO) else $error("start not framed");
  addr_nack_a: assert property (@(posedge mclk) disable iff (rst)
    (byte_end && st_reg == PSS_ADDR && !addr_hit && !start_cnd && !stop_cnd) |=> sda_oe_n)
    else $error("foreign address acknowledged");
  ptr_nack_a: assert property (@(posedge mclk) disable iff (rst)
    (byte_end && st_reg == PSS_WPTR && !ptr_ok && !start_cnd && !stop_cnd) |=> sda_oe_n)
    else $error("unused pointer acknowledged");
  wr_step_a: assert property (@(posedge mclk) disable iff (rst)
    (byte_end && st_reg == PSS_WDAT && !start_cnd && !stop_cnd) |=> ptr_reg == $past(ptr_inc))
    else $error("pointer did not step on write");
  pos_hold_a: assert property (@(posedge mclk) disable iff (rst)
    (byte_end && st_reg == PSS_RDAT && hold_reg && !start_cnd && !stop_cnd) |=> $stable(ptr_reg))
    else $error("pointer moved on position read");

  // Pointer and register-space checks
  ptr_load_a: assert property (@(posedge mclk) disable iff (rst)
    (byte_end && st_reg == PSS_WPTR && !start_cnd && !stop_cnd) |=> ptr_reg == $past(sh_reg))
    else $error("pointer not loaded from first byte");
  rd_step_a: assert property (@(posedge mclk) disable iff (rst)
    (byte_end && st_reg == PSS_RDAT && !hold_reg && !start_cnd && !stop_cnd) |=>
    ptr_reg == $past(ptr_inc)) else $error("pointer did not step on read");
  rd_zero_a: assert property (@(posedge mclk) disable iff (rst)
    (ack_end && st_next == PSS_RDAT && !cur_ok && !start_cnd && !stop_cnd) |=> !sda_oe_n)
    else $error("unused location read as nonzero");
  wr_valid_a: assert property (@(posedge mclk) disable iff (rst)
    wr_stb |-> pss_valid(reg_addr)) else $error("write strobe for unused location");
  busy_start_a: assert property (@(posedge mclk) disable iff (rst)
    start_cnd |=> busy) else $error("busy not raised on start");
endmodule : pss_i2c_slave
`default_nettype wire

// ---- pss_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pss_host_model (
  input  wire logic mclk,
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_low
);
  localparam int HALF = 24;  // 600 ns high, 700 ns low: under 1 MHz
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // Wait whole mclk periods, moving only on the falling edge
  task automatic hold(input int n);
    repeat (n) @(negedge mclk);
  endtask : hold
  // Start or repeated start: data falls while clock is high
  task automatic start();
    sda_low = 1'b0;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    sda_low = 1'b1;
    hold(HALF);
    scl = 1'b0;
    hold(4);
  endtask : start
  // Stop: data rises while clock is high
  task automatic stop();
    sda_low = 1'b1;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    sda_low = 1'b0;
    hold(HALF);
  endtask : stop
  // One bit: data set while clock low, sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    sda_low = ~b;
    hold(HALF);
    scl = 1'b1;
    hold(HALF / 2);
    r = sda;
    hold(HALF / 2);
    scl = 1'b0;
    hold(4);  // Hold time before the next data change
  endtask : bit_io
  // Byte MSB first plus ninth bit; d = 8'hFF releases the line to read
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ack_in, ack);
  endtask : xfer
  // A 25 ns dip on the data line while idle
  task automatic glitch();
    sda_low = 1'b1;
    hold(1);
    sda_low = 1'b0;
    hold(20);
  endtask : glitch
endmodule : pss_host_model
`default_nettype wire

// ---- tb_pss_i2c_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_pss_i2c_slave;
  import pss_pkg::*;
  logic       mclk = 1'b0;
  logic       rst  = 1'b1;
  logic       scl, sda_low, sda_out, sda_oe_n, wr_stb, busy;
  logic [7:0] reg_addr, wr_data, rd_data, q;
  logic       a;
  wire        sda_w = ~(sda_low | (~sda_oe_n & ~sda_out));  // Pulled up when released
  int         fails = 0, checked = 0, cyc = 0, wcnt = 0, bcnt = 0;
  localparam logic [7:0] AW = {PSS_SLAVE_ADDR, 1'b0};
  localparam logic [7:0] AR = {PSS_SLAVE_ADDR, 1'b1};
  always #12.5 mclk = ~mclk;
  assign rd_data = reg_addr ^ 8'hA5;  // Register contents seen by the front end
  pss_host_model host (.mclk(mclk), .sda(sda_w), .scl(scl), .sda_low(sda_low));
  pss_i2c_slave dut (.mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .rd_data(rd_data), .reg_addr(reg_addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .busy(busy));
  ////////////////////////////////////////////////////////////////////////
  // Write strobes, open-drain watch and timeout
  always @(posedge mclk) begin
    cyc++;
    if (wr_stb === 1'b1) wcnt++;
    if (busy === 1'b1) bcnt++;
    if (sda_oe_n === 1'b0 && sda_out !== 1'b0) begin
      fails++;
      $display("mismatch sda_out expected 0 seen %b", sda_out);
    end
    if (cyc == 60000) begin
      fails++;
      $display("mismatch timeout expected below %0d seen %0d", 60000, cyc);
      finish_test();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic finish_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////
  // Pointer write, then three reads from it
  task automatic rd3(input logic [7:0] p, input logic pa, input logic [7:0] e0, e1, e2);
    host.start();
    host.xfer(AW, 1'b1, q, a);
    host.xfer(p, 1'b1, q, a);
    chk("ptr_ack", pa, a);
    host.start();
    host.xfer(AR, 1'b1, q, a);
    host.xfer(8'hFF, 1'b0, q, a);
    chk("rd0", e0, q);
    host.xfer(8'hFF, 1'b0, q, a);
    chk("rd1", e1, q);
    host.xfer(8'hFF, 1'b1, q, a);
    chk("rd2", e2, q);
    host.stop();
  endtask : rd3
  task automatic t_write();
    int w0 = wcnt;
    host.start();
    host.xfer(AW, 1'b1, q, a);
    chk("addr_ack", 8'h00, a);
    host.xfer(8'h01, 1'b1, q, a);
    host.xfer(8'h5A, 1'b1, q, a);
    chk("wdata", 8'h5A, wr_data);
    host.xfer(8'h3C, 1'b1, q, a);
    chk("wdata2", 8'h3C, wr_data);
    chk("busy_on", 8'h01, busy);
    host.stop();
    chk("busy_off", 8'h00, busy);
    chk("wcount", 8'h02, 8'(wcnt - w0));
    chk("waddr", 8'h03, reg_addr);
  endtask : t_write
  task automatic t_bad_write();
    int w0 = wcnt;
    host.start();
    host.xfer(AW, 1'b1, q, a);
    host.xfer(8'h09, 1'b1, q, a);
    chk("bad_ptr", 8'h01, a);
    host.xfer(8'h11, 1'b1, q, a);
    chk("bad_w09", 8'h01, a);
    host.xfer(8'h22, 1'b1, q, a);
    chk("bad_w0a", 8'h01, a);
    host.xfer(8'h33, 1'b1, q, a);
    chk("ok_w0b", 8'h00, a);
    host.stop();
    chk("bad_wcount", 8'h01, 8'(wcnt - w0));
  endtask : t_bad_write
  task automatic t_foreign();
    int w0 = wcnt;
    host.start();
    host.xfer({7'h37, 1'b0}, 1'b1, q, a);
    chk("foreign_ack", 8'h01, a);
    host.xfer(8'h01, 1'b1, q, a);
    chk("foreign_ptr", 8'h01, a);
    host.stop();
    chk("foreign_wr", 8'h00, 8'(wcnt - w0));
  endtask : t_foreign
  task automatic t_glitch();
    int b0 = bcnt;
    host.glitch();
    chk("glitch_busy", 8'h00, busy);
    chk("glitch_start", 8'h00, 8'(bcnt - b0));
  endtask : t_glitch
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    repeat (10) @(negedge mclk);
    t_write();
    t_bad_write();
    t_foreign();
    t_glitch();
    rd3(8'hFE, 1'b1, 8'h00, 8'h5A, 8'hA5);
    rd3(PSS_RAW_HI, 1'b0, 8'hA9, 8'hA9, 8'hA9);
    rd3(8'h0D, 1'b0, 8'hA8, 8'hAB, 8'hAA);
    rd3(8'h0F, 1'b0, 8'hAA, 8'hB5, 8'h00);
    finish_test();
  end
endmodule : tb_pss_i2c_slave
`default_nettype wire
